/* File: rtl/hass_seq.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: software or peripheral trigger starts its group
// R2: set group active flag on start
// R3: set converter active flag on start
// R4: next channel after every single oversampling
// R5: first result after tap times average samples
// R6: write each result into result register
// R7: also push result to group fifo register
// R8: scan-end interrupt after all group channels
// R9: later samples update filter, not restart
// R10: later results every one or average samples
// R11: keep filter contents across rounds
// R12: repeat rounds until forced stop
// R13: software stops only through forced stop
// R14: software keeps digital filter enabled
// R15: forced stop clears active flags
module hass_seq
	import hass_pkg::*;
(
	// clock and reset
	input  wire logic                   sys_clk_i,
	input  wire logic                   nrst_i,
	input  wire logic                   clk_en_i,
	// triggers
	input  wire logic                   sw_trig_i,
	input  wire logic                   per_trig_i,
	input  wire logic [GRP_W-1:0]       trig_group_i,
	input  wire logic                   force_stop_i,
	// configuration
	input  wire logic                   conv_sel_i,
	input  wire logic [VCH_W-1:0]       last_vch_i,
	input  wire logic [RES_W*NUM_VCH-1:0] vch_result_map_i,
	input  wire logic [CNT_W-1:0]       tap_cnt_i,
	input  wire logic [CNT_W-1:0]       avg_cnt_i,
	input  wire logic                   avg_each_i,
	input  wire logic                   fifo_en_i,
	input  wire logic                   scan_end_ie_i,
	// analog front end
	output logic                        sample_req_o,
	output logic [VCH_W-1:0]            vch_o,
	input  wire logic                   sample_done_i,
	input  wire logic [DATA_W-1:0]      sample_data_i,
	// status and results
	output logic [NUM_GROUPS-1:0]       group_active_flag_o,
	output logic [NUM_CONV-1:0]         converter_active_flag_o,
	output hass_pkg::hass_result_type   result_o,
	output hass_pkg::hass_result_type   fifo_result_o,
	output logic                        scan_end_irq_o,
	output logic [GRP_W-1:0]            scan_end_group_o
);
	import hass_pkg::*;

	typedef enum logic [2:0]
	{
		ST_IDLE   = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_WAIT   = 3'b100
	} hass_state_type;

	typedef struct packed
	{
		hass_state_type            st;
		logic [GRP_W-1:0]          grp;
		logic [VCH_W-1:0]          vch;
		logic [VCH_W-1:0]          res_vch;
		logic [NUM_VCH-1:0]        done;
		logic                      req;
		logic [NUM_GROUPS-1:0]     gact;
		logic [NUM_CONV-1:0]       cact;
		hass_result_type           res;
		hass_result_type           fifo;
		logic                      irq;
		logic [GRP_W-1:0]          irq_grp;
	} hass_seq_state_type;

	hass_seq_state_type state_reg;
	hass_seq_state_type state_next;

	logic                  filt_valid;
	logic [DATA_W-1:0]     filt_data;
	logic                  filt_clear;
	logic                  filt_sample;
	logic [CNT_W-1:0]      first_cnt;
	logic [CNT_W-1:0]      next_cnt;

	function automatic logic [VCH_W-1:0] next_vch(input logic [VCH_W-1:0] v,
		input logic [VCH_W-1:0] last);
		next_vch = (v >= last) ? '0 : v + 3'h1;
	endfunction

	function automatic logic [RES_W-1:0] map_res(input logic [VCH_W-1:0] v,
		input logic [RES_W*NUM_VCH-1:0] m);
		map_res = m[v*RES_W +: RES_W];
	endfunction

	wire start = (sw_trig_i | per_trig_i) && (trig_group_i < GRP_W'(NUM_GROUPS));
	// see R5: initial delay = tap count times averaging count
	assign first_cnt   = CNT_W'(tap_cnt_i * ((avg_cnt_i == '0) ? ONE_CNT : avg_cnt_i));
	assign next_cnt    = avg_each_i ? avg_cnt_i : ONE_CNT; // see R10
	assign filt_clear  = state_reg.st == ST_IDLE && start;
	assign filt_sample = state_reg.st == ST_WAIT && sample_done_i;

	hass_filter u_filter
	(
		.sys_clk_i   (sys_clk_i),
		.nrst_i      (nrst_i),
		.clk_en_i    (clk_en_i),
		.clear_i     (filt_clear),
		.sample_i    (filt_sample),
		.vch_i       (state_reg.vch),
		.data_i      (sample_data_i),
		.first_cnt_i (first_cnt),
		.next_cnt_i  (next_cnt),
		.out_valid_o (filt_valid),
		.out_data_o  (filt_data)
	);

	always_comb
	begin
		logic [NUM_VCH-1:0] d;
		logic [NUM_VCH-1:0] m;
		d = '0;
		// channels 0..last belong to the group; a round ends when all have a result
		m = '0;
		for (int i = 0; i < NUM_VCH; i++)
			m[i] = (VCH_W'(i) <= last_vch_i);
		state_next = state_reg;
		state_next.res.valid = 1'b0;
		state_next.fifo.valid = 1'b0;
		state_next.irq = 1'b0;
		state_next.req = 1'b0;
		if (filt_valid)
		begin
			// see R6
			state_next.res.valid = 1'b1;
			state_next.res.data  = filt_data;
			state_next.res.index = map_res(state_reg.res_vch, vch_result_map_i);
			state_next.res.group = state_reg.grp;
			// see R7
			state_next.fifo = state_next.res;
			state_next.fifo.valid = fifo_en_i;
			d = state_reg.done;
			d[state_reg.res_vch] = 1'b1;
			state_next.done = d;
			// see R8: all group channels converted this round
			if ((d & m) == m)
			begin
				state_next.irq = scan_end_ie_i;
				state_next.irq_grp = state_reg.grp;
				state_next.done = '0;
			end
		end
		case (state_reg.st)
			ST_IDLE:
			begin
				if (start)
				begin
					state_next.st = ST_SAMPLE; // see R1
					state_next.grp = trig_group_i;
					state_next.vch = '0;
					state_next.done = '0;
					state_next.gact[trig_group_i] = 1'b1; // see R2
					state_next.cact[conv_sel_i] = 1'b1; // see R3
				end
			end
			ST_SAMPLE:
			begin
				state_next.req = 1'b1;
				state_next.st = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (sample_done_i)
				begin
					state_next.res_vch = state_reg.vch;
					state_next.vch = next_vch(state_reg.vch, last_vch_i); // see R4
					state_next.st = ST_SAMPLE; // see R12
				end
			end
			default:
				state_next.st = ST_IDLE;
		endcase
		// see R13: stop honoured only through the forced-stop input
		if (force_stop_i)
		begin
			state_next.st = ST_IDLE;
			state_next.gact = '0; // see R15
			state_next.cact = '0;
			state_next.done = '0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_reg <= '0;
			state_reg.st <= ST_IDLE;
		end
		else if (clk_en_i)
			state_reg <= state_next;
	end

	assign sample_req_o            = state_reg.req;
	assign vch_o                   = state_reg.vch;
	assign group_active_flag_o     = state_reg.gact;
	assign converter_active_flag_o = state_reg.cact;
	assign result_o                = state_reg.res;
	assign fifo_result_o           = state_reg.fifo;
	assign scan_end_irq_o          = state_reg.irq;
	assign scan_end_group_o        = state_reg.irq_grp;

	AST_START_FLAG: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see R2
		clk_en_i && state_reg.st == ST_IDLE && start && !force_stop_i
		|=> group_active_flag_o[$past(trig_group_i)])
		else $error("group flag not set on start");
	AST_CONV_FLAG: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see R3
		clk_en_i && state_reg.st == ST_IDLE && start && !force_stop_i
		|=> converter_active_flag_o[$past(conv_sel_i)])
		else $error("converter flag not set on start");
	AST_STOP_CLR: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see R15
		clk_en_i && force_stop_i |=> group_active_flag_o == '0 && converter_active_flag_o == '0)
		else $error("flags not cleared by stop");
	AST_CH_STEP: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see R4
		clk_en_i && state_reg.st == ST_WAIT && sample_done_i && !force_stop_i
		|=> vch_o == next_vch($past(vch_o), $past(last_vch_i)))
		else $error("channel did not advance");
	AST_FIFO: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see R7
		fifo_result_o.valid |-> result_o.valid && fifo_result_o.data == result_o.data)
		else $error("fifo result mismatch");
	AST_IRQ: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see R8
		scan_end_irq_o |-> result_o.valid && $past(scan_end_ie_i))
		else $error("scan end without result");
	AST_REPEAT: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see R12
		clk_en_i && state_reg.st == ST_SAMPLE && !force_stop_i |=> sample_req_o)
		else $error("scan did not continue");
	AST_RES_SRC: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see R6
		clk_en_i && filt_valid |=> result_o.valid && result_o.data == $past(filt_data))
		else $error("result not stored");
	COV_START: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		state_reg.st == ST_IDLE ##1 state_reg.st == ST_SAMPLE);
	COV_IRQ: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) scan_end_irq_o);
	COV_STOP: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		force_stop_i && state_reg.st == ST_WAIT);
endmodule

/* File: rtl/hass_pkg.sv */
package hass_pkg;
	localparam int NUM_GROUPS      = 9;
	localparam int NUM_CONV        = 2;
	localparam int NUM_VCH         = 8;
	localparam int NUM_RESULTS     = 29;
	localparam int DATA_W          = 16;
	localparam int CNT_W           = 8;
	localparam int VCH_W           = 3;
	localparam int GRP_W           = 4;
	localparam int RES_W           = 5;
	localparam int ACC_W           = 24;
	localparam logic [CNT_W-1:0] ONE_CNT = 8'h01;

	typedef struct packed
	{
		logic [DATA_W-1:0] data;
		logic [RES_W-1:0]  index;
		logic [GRP_W-1:0]  group;
		logic              valid;
	} hass_result_type;

	typedef struct packed
	{
		logic [DATA_W-1:0] data;
		logic              valid;
	} hass_sample_type;
endpackage

/* File: rtl/hass_filter.sv */
`timescale 1ns/1ps
// per-channel filter state; kept between rounds, cleared only on start
module hass_filter
	import hass_pkg::*;
(
	// clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  nrst_i,
	input  wire logic                  clk_en_i,
	// control
	input  wire logic                  clear_i,
	input  wire logic                  sample_i,
	input  wire logic [VCH_W-1:0]      vch_i,
	input  wire logic [DATA_W-1:0]     data_i,
	input  wire logic [CNT_W-1:0]      first_cnt_i,
	input  wire logic [CNT_W-1:0]      next_cnt_i,
	// result
	output logic                       out_valid_o,
	output logic [DATA_W-1:0]          out_data_o
);
	import hass_pkg::*;

	typedef struct packed
	{
		logic [NUM_VCH-1:0][ACC_W-1:0] acc;
		logic [NUM_VCH-1:0][CNT_W-1:0] cnt;
		logic [NUM_VCH-1:0]            primed;
		logic                          valid;
		logic [DATA_W-1:0]             data;
	} hass_filt_state_type;

	hass_filt_state_type state_reg;
	hass_filt_state_type state_next;

	always_comb
	begin
		logic [CNT_W-1:0] need;
		logic [CNT_W-1:0] n;
		need = '0;
		n = '0;
		state_next = state_reg;
		state_next.valid = 1'b0;
		if (clear_i)
		begin
			state_next.acc = '0;
			state_next.cnt = '0;
			state_next.primed = '0;
		end
		else if (sample_i)
		begin
			// see R5 see R10
			need = state_reg.primed[vch_i] ? next_cnt_i : first_cnt_i;
			if (need == '0)
				need = ONE_CNT;
			n = state_reg.cnt[vch_i] + ONE_CNT;
			// see R9 see R11
			state_next.acc[vch_i] = state_reg.acc[vch_i] - (state_reg.acc[vch_i] >> 2)
				+ ACC_W'(data_i);
			if (n >= need)
			begin
				state_next.cnt[vch_i] = '0;
				state_next.primed[vch_i] = 1'b1;
				state_next.valid = 1'b1;
				state_next.data = state_next.acc[vch_i][DATA_W+1:2];
			end
			else
				state_next.cnt[vch_i] = n;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state_reg <= '0;
		else if (clk_en_i)
			state_reg <= state_next;
	end

	assign out_valid_o = state_reg.valid;
	assign out_data_o  = state_reg.data;
endmodule

/* File: bench/hass_fe_model.sv */
`timescale 1ns/1ps
// front end: answers each request 3 or 5 cycles later, data line inverted once as done drops
module hass_fe_model
	import hass_pkg::*;
(
	// clock
	input  wire logic              sys_clk_i,
	// request
	input  wire logic              sample_req_i,
	input  wire logic [VCH_W-1:0]  vch_i,
	// answer
	output logic                   sample_done_o,
	output logic [DATA_W-1:0]      sample_data_o
);
	int n = 0;
	initial
	begin
		sample_done_o = 1'b0;
		sample_data_o = 16'h0000;
		forever
		begin
			@(posedge sys_clk_i);
			if (sample_req_i === 1'b1)
			begin
				repeat (n[0] ? 5 : 3) @(posedge sys_clk_i);
				#1;
				sample_done_o = 1'b1;
				sample_data_o = 16'h4000 + {13'h0000, vch_i} + n[15:0];
				n++;
				@(posedge sys_clk_i);
				#1;
				sample_done_o = 1'b0;
				sample_data_o = ~sample_data_o;
			end
		end
	end
endmodule

/* File: bench/hybrid_adc_scan_sequencer_tb.sv */
`timescale 1ns/1ps
module hybrid_adc_scan_sequencer_tb;
	import hass_pkg::*;
	typedef struct packed
	{
		logic              sw;
		logic [GRP_W-1:0]  grp;
		logic              conv;
		logic [CNT_W-1:0]  tap;
		logic [CNT_W-1:0]  avg;
		logic              each;
		logic              fifo;
		logic              ie;
		logic [VCH_W-1:0]  last;
	} hass_row_type;
	localparam logic [RES_W*NUM_VCH-1:0] MAP = {30'h00000000, 5'h1c, 5'h03};
	localparam hass_row_type ROWS [3] = '{
		'{1'b1, 4'h2, 1'b1, 8'h02, 8'h01, 1'b0, 1'b1, 1'b1, 3'h1},
		'{1'b0, 4'h8, 1'b0, 8'h01, 8'h02, 1'b1, 1'b0, 1'b0, 3'h1},
		'{1'b1, 4'h0, 1'b0, 8'h03, 8'h01, 1'b1, 1'b1, 1'b1, 3'h2}};
	logic sys_clk;
	logic nrst;
	logic go;
	logic stop;
	hass_row_type cfg;
	logic req;
	logic [VCH_W-1:0] vch;
	logic done;
	logic [DATA_W-1:0] data;
	logic [NUM_GROUPS-1:0] gaf;
	logic [NUM_CONV-1:0] caf;
	hass_result_type res;
	hass_result_type fres;
	logic irq;
	logic [GRP_W-1:0] igrp;
	logic [VCH_W-1:0] lastch;
	int bad_count = 0;
	int cmp_count = 0;
	int nreq;
	int ndone;
	int nres;
	int nfifo;
	int nirq;
	int e;
	logic en;
	// reference filter state per channel: acc = acc - acc/4 + sample
	logic [ACC_W-1:0] acc [NUM_VCH];
	hass_seq hass_seq_i (.sys_clk_i(sys_clk), .nrst_i(nrst), .clk_en_i(en),
		.sw_trig_i(go & cfg.sw), .per_trig_i(go & ~cfg.sw), .trig_group_i(cfg.grp),
		.force_stop_i(stop), .conv_sel_i(cfg.conv), .last_vch_i(cfg.last),
		.vch_result_map_i(MAP), .tap_cnt_i(cfg.tap), .avg_cnt_i(cfg.avg),
		.avg_each_i(cfg.each), .fifo_en_i(cfg.fifo), .scan_end_ie_i(cfg.ie),
		.sample_req_o(req), .vch_o(vch), .sample_done_i(done), .sample_data_i(data),
		.group_active_flag_o(gaf), .converter_active_flag_o(caf), .result_o(res),
		.fifo_result_o(fres), .scan_end_irq_o(irq), .scan_end_group_o(igrp));
	hass_fe_model hass_fe_model_i (.sys_clk_i(sys_clk), .sample_req_i(req), .vch_i(vch),
		.sample_done_o(done), .sample_data_o(data));
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		begin
			cmp_count++;
			if (got !== exp)
			begin
				bad_count++;
				$display("[FAIL] %s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task automatic close_out;
		begin
			if (bad_count == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// pulse one input for one cycle, launched just after an edge
	task automatic trigger(input hass_row_type r);
		begin
			@(posedge sys_clk);
			#1;
			cfg = r;
			nreq = 0;
			ndone = 0;
			nres = 0;
			nfifo = 0;
			nirq = 0;
			foreach (acc[j])
				acc[j] = '0;
			go = 1'b1;
			@(posedge sys_clk);
			#1;
			go = 1'b0;
		end
	endtask
	task automatic halt;
		begin
			stop = 1'b1;
			@(posedge sys_clk);
			#1;
			stop = 1'b0;
			@(posedge sys_clk);
			#1;
			check("group_active", 0, gaf);
			check("conv_active", 0, caf);
		end
	endtask
	always @(posedge sys_clk)
	begin
		if (req === 1'b1)
		begin
			check("vch", nreq % (cfg.last + 1), vch);
			nreq++;
		end
		if (done === 1'b1)
		begin
			lastch = vch;
			acc[vch] = acc[vch] - (acc[vch] >> 2) + ACC_W'(data);
			ndone++;
		end
		if (res.valid === 1'b1)
		begin
			nres++;
			check("res_index", MAP[lastch*RES_W +: RES_W], res.index);
			check("res_group", cfg.grp, res.group);
			check("res_data", acc[lastch][DATA_W+1:2], res.data);
		end
		if (fres.valid === 1'b1)
		begin
			nfifo++;
			check("fifo_data", acc[lastch][DATA_W+1:2], fres.data);
			check("fifo_index", MAP[lastch*RES_W +: RES_W], fres.index);
			check("fifo_group", cfg.grp, fres.group);
		end
		if (irq === 1'b1)
		begin
			nirq++;
			check("irq_group", cfg.grp, igrp);
		end
	end
	initial
	begin
		sys_clk = 1'b0;
		forever
			#2 sys_clk = ~sys_clk;
	end
	initial
	begin
		#20000;
		bad_count++;
		close_out();
	end
	initial
	begin
		nrst = 1'b0;
		go = 1'b0;
		stop = 1'b0;
		en = 1'b1;
		cfg = ROWS[0];
		repeat (5) @(posedge sys_clk);
		#1;
		check("reset_flags", 0, {gaf, caf, res.valid, irq});
		nrst = 1'b1;
		foreach (ROWS[i])
		begin
			trigger(ROWS[i]);
			@(posedge sys_clk);
			#1;
			check("group_active", 1 << cfg.grp, gaf);
			check("conv_active", 1 << cfg.conv, caf);
			for (int k = 0; k < 400 && ndone < 5 * (cfg.last + 1); k++)
				@(posedge sys_clk);
			repeat (2) @(posedge sys_clk);
			#1;
			halt();
			repeat (8) @(posedge sys_clk);
			// five samples per channel; first result after tap*avg of them
			e = cfg.each ? (5 - cfg.tap * cfg.avg) / cfg.avg + 1 : 6 - cfg.tap * cfg.avg;
			check("results", (cfg.last + 1) * e, nres);
			check("fifo", cfg.fifo ? (cfg.last + 1) * e : 0, nfifo);
			check("irqs", cfg.ie ? e : 0, nirq);
		end
		// clock enable low: a trigger must not be taken
		#1;
		en = 1'b0;
		trigger(ROWS[2]);
		repeat (3) @(posedge sys_clk);
		#1;
		check("frozen", 0, {gaf, caf, req});
		en = 1'b1;
		// group beyond the last one is ignored
		trigger(hass_row_type'{1'b1, 4'h9, 1'b0, 8'h01, 8'h01, 1'b0, 1'b0, 1'b0, 3'h1});
		repeat (6) @(posedge sys_clk);
		#1;
		check("bad_group", 0, {gaf, nreq[7:0]});
		// reset in mid-scan, then a trigger taken at the second edge after release
		trigger(ROWS[0]);
		repeat (6) @(posedge sys_clk);
		#1;
		nrst = 1'b0;
		#1;
		check("mid_reset", 0, {gaf, caf, req});
		@(posedge sys_clk);
		#1;
		nrst = 1'b1;
		trigger(ROWS[1]);
		@(posedge sys_clk);
		#1;
		check("restart_group", 9'h100, gaf);
		halt();
		close_out();
	end
endmodule
